// [logic/qud_datapath.sv]
// Purpose: I/Q interpolation, quadrature modulation and droop correction
// Assumes: One core sample clock; sample words arrive I first, then Q
// Notes:   Profile fields are taken live from the selected profile
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RULE_01: Two half-band stages give fixed 4x
// RULE_02: Two input words make one I/Q pair
// RULE_03: Half-band passband flat to 80% Nyquist
// RULE_04: Half-band stopband 120-400% Nyquist, 85 dB
// RULE_05: Half-bands linear phase, near unity gain
// RULE_06: Source oversamples baseband by two
// RULE_07: Six-bit CIC rate, two to sixty-three
// RULE_08: Bypass bit forces CIC rate one, unpowered
// RULE_09: CIC bypass also bypasses inverse CIC
// RULE_10: Total upsampling is four times CIC rate
// RULE_11: CIC is fifth-order boxcar response
// RULE_12: Sum I times cosine and Q times sine
// RULE_13: Modulator takes new I/Q every clock
// RULE_14: Invert bit picks plus, else minus
// RULE_15: 32-bit tuning word drives phase accumulator
// RULE_16: Tuning word kept below half clock
// RULE_17: Profile one word at 0x08 to 0x0B
// RULE_18: Inverse sinc FIR corrects hold droop
// RULE_19: Inverse sinc lowers low-frequency gain
// RULE_20: Bypassed inverse sinc is passed and frozen
// RULE_21: Output stream at core clock rate
// RULE_22: All timing from the core clock
// RULE_23: Control 0x06 bit zero bypasses inverse CIC
// RULE_24: Input is 14-bit two's complement words
// RULE_25: Internal widths sized for stated attenuation
// RULE_26: Profile select picks rate, bits, word
module qud_datapath (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [13:0] in_data,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic        tx_enable,
    input  wire logic [1:0]  profile_sel,
    input  wire logic [5:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    output logic [7:0]       reg_rdata,
    output logic [13:0]      dac_data,
    output logic             pair_underrun
);
    typedef struct packed {
        logic [3:0][31:0]      tw;
        logic [3:0][7:0]       cfg;
        logic [7:0]            ctl;
        logic [7:0]            rdata;
        logic                  have_i;
        logic [15:0]           i_hold;
        logic                  pair_full;
        logic [1:0][15:0]      pair;
        logic                  underrun;
        logic [5:0]            cic_cnt;
        logic [1:0]            q_cnt;
        logic [1:0][2:0][15:0] icic;
        logic [1:0][3:0][15:0] hb1;
        logic [1:0][3:0][15:0] hb2;
        logic [1:0][4:0][39:0] comb;
        logic [1:0][4:0][39:0] integ;
        logic [1:0][15:0]      hold;
        logic [1:0][15:0]      iq;
        logic [31:0]           phase;
        logic [11:0]           cosv;
        logic [11:0]           sinv;
        logic [16:0]           mod;
        logic [2:0][16:0]      isinc;
        logic [13:0]           dac;
        logic [5:0]            rate;
    } qud_state_type;

    qud_state_type r;
    qud_state_type n;

    logic                    fifo_ov;
    logic                    fifo_rd;
    logic [13:0]             fifo_od;
    logic [31:0]             tw_act;
    logic [7:0]              cfg_act;
    logic                    cic_byp;
    logic                    icic_byp;
    logic                    isinc_en;
    logic                    inv;
    logic [5:0]              rate_eff;
    logic [4:0]              cic_sh;
    logic                    tick;
    logic                    pair_tick;
    logic signed [27:0]      prod_i;
    logic signed [27:0]      prod_q;
    logic signed [28:0]      msum;

    localparam logic signed [19:0] QUD_HB_C_LOC    = qud_pkg::QUD_HB_C;
    localparam logic signed [17:0] QUD_ICIC_C_LOC  = qud_pkg::QUD_ICIC_C;
    localparam logic signed [21:0] QUD_ISINC_C_LOC = qud_pkg::QUD_ISINC_C;

    // Half-band polyphase: even phase is the centre tap, odd phase interpolates
    function automatic logic [15:0] qud_hb(input logic [3:0][15:0] d, input logic odd);
        logic signed [19:0] s;
        s = QUD_HB_C_LOC * ($signed(d[1]) + $signed(d[2])) - ($signed(d[0]) + $signed(d[3]));
        s = s >>> qud_pkg::QUD_HB_SHIFT;
        return odd ? s[15:0] : d[2];
    endfunction : qud_hb

    function automatic logic [11:0] qud_sine(input logic [5:0] p);
        logic [10:0] m;
        m = p[4] ? qud_pkg::QUD_SINE_LUT[4'hF - p[3:0]] : qud_pkg::QUD_SINE_LUT[p[3:0]];
        return p[5] ? 12'(-$signed({1'b0, m})) : {1'b0, m};
    endfunction : qud_sine

    function automatic logic [2:0] qud_log2_up(input logic [5:0] v);
        logic [2:0] c;
        c = 3'h0;
        for (int k = 0; k < 6; k++) begin
            if ((7'h01 << k) < {1'b0, v}) begin
                c = 3'(k + 1);
            end
        end
        return c;
    endfunction : qud_log2_up

    function automatic logic [13:0] qud_sat(input logic signed [21:0] v);
        if (v > qud_pkg::QUD_DAC_MAX) begin
            return 14'h1FFF;
        end
        if (v < qud_pkg::QUD_DAC_MIN) begin
            return 14'h2000;
        end
        return v[13:0];
    endfunction : qud_sat

    qud_fifo #(
        .W     (qud_pkg::QUD_IN_W),
        .DEPTH (qud_pkg::QUD_FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .resetn    (resetn),
        .in_data   (in_data),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .out_data  (fifo_od),
        .out_valid (fifo_ov),
        .out_ready (fifo_rd)
    );

    // Live profile fields, no update strobe needed
    assign tw_act   = r.tw[profile_sel];                                    // [RULE_26]
    assign cfg_act  = r.cfg[profile_sel];                                   // [RULE_26]
    assign cic_byp  = cfg_act[qud_pkg::QUD_CFG_BYP];
    assign inv      = cfg_act[qud_pkg::QUD_CFG_INV];
    assign icic_byp = cic_byp | r.ctl[qud_pkg::QUD_CTL_ICIC_BYP];            // [RULE_09] [RULE_23]
    assign isinc_en = r.ctl[qud_pkg::QUD_CTL_ISINC_EN];
    // Rates below two are clamped to two; only the bypass bit gives rate one
    assign rate_eff = cic_byp ? qud_pkg::QUD_RATE_BYP :
                      (cfg_act[5:0] < qud_pkg::QUD_RATE_MIN) ? qud_pkg::QUD_RATE_MIN :
                      cfg_act[5:0];                                          // [RULE_07] [RULE_08]
    // Shift rounds the R^4 gain up to a power of two, trading a little level for no overflow
    assign cic_sh   = 5'(qud_log2_up(rate_eff)) * 5'(qud_pkg::QUD_CIC_LOG_MUL); // [RULE_25]
    assign tick      = (r.cic_cnt >= rate_eff - 6'h01);                       // [RULE_22]
    assign pair_tick = tick && (r.q_cnt == qud_pkg::QUD_Q_LAST);              // [RULE_10]
    assign fifo_rd   = tx_enable ? !r.pair_full : 1'b1;
    assign prod_i    = $signed(r.iq[0]) * $signed(r.cosv);                    // [RULE_12]
    assign prod_q    = $signed(r.iq[1]) * $signed(r.sinv);                    // [RULE_12]
    assign msum      = inv ? prod_i + prod_q : prod_i - prod_q;               // [RULE_14]

    always_comb begin
        logic [1:0][15:0]   pin;
        logic [15:0]        h;
        logic [39:0]        x;
        logic [39:0]        y;
        logic [39:0]        acc;
        logic signed [39:0] t;
        logic signed [17:0] e;
        logic signed [17:0] v;
        logic signed [21:0] sel;
        pin = '0;
        h   = '0;
        x   = '0;
        y   = '0;
        acc = '0;
        t   = '0;
        e   = '0;
        v   = '0;
        sel = '0;
        n   = r;

        // Byte control registers
        if (reg_write) begin
            if (reg_addr == qud_pkg::QUD_ADDR_CTL) begin
                n.ctl = reg_wdata;
            end
            for (int p = 0; p < qud_pkg::QUD_NPROF; p++) begin
                if (reg_addr[5:3] == qud_pkg::QUD_PROF_BLK0 + 3'(p)) begin
                    if (reg_addr[2:0] < qud_pkg::QUD_OFS_CFG) begin
                        n.tw[p][8*reg_addr[1:0] +: 8] = reg_wdata;            // [RULE_17]
                    end else if (reg_addr[2:0] == qud_pkg::QUD_OFS_CFG) begin
                        n.cfg[p] = reg_wdata;
                    end
                end
            end
        end
        n.rdata = qud_pkg::QUD_REG_RST;
        if (reg_addr == qud_pkg::QUD_ADDR_CTL) begin
            n.rdata = r.ctl;
        end
        for (int p = 0; p < qud_pkg::QUD_NPROF; p++) begin
            if (reg_addr[5:3] == qud_pkg::QUD_PROF_BLK0 + 3'(p)) begin
                if (reg_addr[2:0] < qud_pkg::QUD_OFS_CFG) begin
                    n.rdata = r.tw[p][8*reg_addr[1:0] +: 8];
                end else if (reg_addr[2:0] == qud_pkg::QUD_OFS_CFG) begin
                    n.rdata = r.cfg[p];
                end
            end
        end

        // Rate counters: CIC phase, then four half-band phases per pair
        n.cic_cnt = tick ? 6'h00 : r.cic_cnt + 6'h01;                         // [RULE_10]
        n.rate    = rate_eff;                                                 // [RULE_26]
        if (tick) begin
            n.q_cnt = r.q_cnt + 2'h1;                                         // [RULE_01]
        end

        // Pair consumption; an empty slot sends zeros down the path
        n.underrun = 1'b0;
        if (pair_tick) begin
            pin         = r.pair_full ? r.pair : '0;
            n.underrun  = tx_enable && !r.pair_full;
            n.pair_full = 1'b0;
        end

        // Assembler: I word then Q word; fill after consume so set wins
        if (!tx_enable) begin
            n.have_i    = 1'b0;
            n.pair_full = 1'b0;
        end else if (fifo_ov && fifo_rd) begin
            if (!r.have_i) begin
                n.i_hold = {{2{fifo_od[13]}}, fifo_od};                        // [RULE_24]
                n.have_i = 1'b1;
            end else begin
                n.pair[0]   = r.i_hold;                                       // [RULE_02]
                n.pair[1]   = {{2{fifo_od[13]}}, fifo_od};                    // [RULE_24]
                n.pair_full = 1'b1;                                           // [RULE_02]
                n.have_i    = 1'b0;
            end
        end

        for (int ch = 0; ch < 2; ch++) begin
            // Inverse CIC: three-tap peaking ahead of the half-bands
            if (pair_tick) begin
                if (icic_byp) begin
                    n.hb1[ch] = {r.hb1[ch][2:0], pin[ch]};                    // [RULE_09] [RULE_23]
                end else begin
                    n.icic[ch] = {r.icic[ch][1:0], pin[ch]};
                    e = QUD_ICIC_C_LOC * $signed(r.icic[ch][0])
                        - $signed(pin[ch]) - $signed(r.icic[ch][1]);
                    v = $signed(r.icic[ch][0]) + (e >>> qud_pkg::QUD_ICIC_SHIFT);
                    n.hb1[ch] = {r.hb1[ch][2:0], v[15:0]};
                end
            end
            // Second half-band takes first half-band output at twice pair rate
            if (tick && r.q_cnt[0]) begin
                n.hb2[ch] = {r.hb2[ch][2:0], qud_hb(r.hb1[ch], r.q_cnt[1])};  // [RULE_01] [RULE_05]
            end
            h = qud_hb(r.hb2[ch], r.q_cnt[0]);                                // [RULE_03] [RULE_04]

            // Fifth-order CIC: combs at input rate, zero-stuffed integrators
            x = {{24{h[15]}}, h};
            for (int k = 0; k < qud_pkg::QUD_CIC_ORDER; k++) begin
                y = x - r.comb[ch][k];
                if (tick) begin
                    n.comb[ch][k] = x;                                        // [RULE_11]
                end
                x = y;
            end
            acc = tick ? x : '0;
            for (int k = 0; k < qud_pkg::QUD_CIC_ORDER; k++) begin
                acc = r.integ[ch][k] + acc;
                n.integ[ch][k] = acc;                                         // [RULE_11]
            end
            // A live rate change strands integrator sums, so restart as well
            if (cic_byp || (rate_eff != r.rate)) begin
                n.comb[ch]  = '0;                                             // [RULE_08]
                n.integ[ch] = '0;                                             // [RULE_08]
            end
            if (tick) begin
                n.hold[ch] = h;
            end
            t = $signed(r.integ[ch][4]) >>> cic_sh;
            n.iq[ch] = cic_byp ? r.hold[ch] : t[15:0];                        // [RULE_13]
        end

        // Carrier synthesis: quarter-wave table, cosine leads sine by 90 degrees
        n.phase = r.phase + tw_act;                                           // [RULE_15]
        n.sinv  = qud_sine(r.phase[31:26]);
        n.cosv  = qud_sine(r.phase[31:26] + qud_pkg::QUD_QUARTER);            // [RULE_12]
        n.mod   = 17'(msum >>> qud_pkg::QUD_MOD_SHIFT);                       // [RULE_14]

        // Inverse sinc: frozen taps stand in for a stopped clock
        if (isinc_en) begin
            n.isinc = {r.isinc[1:0], r.mod};                                  // [RULE_18]
            sel = (QUD_ISINC_C_LOC * $signed(r.isinc[1]) - $signed(r.isinc[0])
                   - $signed(r.isinc[2])) >>> qud_pkg::QUD_ISINC_SHIFT;       // [RULE_19]
        end else begin
            sel = 22'($signed(r.mod));                                        // [RULE_20]
        end
        n.dac = qud_sat(sel);                                                 // [RULE_21]
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata     = r.rdata;
    assign dac_data      = r.dac;
    assign pair_underrun = r.underrun;

    a_asm_stall: assert property (@(posedge clock) disable iff (!resetn) // [RULE_02]
        (tx_enable && r.pair_full && !pair_tick) |=> $stable(r.pair))
        else $error("waiting pair overwritten before use");

    a_asm_pair: assert property (@(posedge clock) disable iff (!resetn) // [RULE_02]
        (tx_enable && fifo_ov && fifo_rd && r.have_i) |=> r.pair_full)
        else $error("second word did not complete a pair");

    a_cic_rate_one: assert property (@(posedge clock) disable iff (!resetn) // [RULE_08]
        (cic_byp && $past(cic_byp)) |-> tick)
        else $error("bypassed interpolator not at rate one");

    a_cic_unpowered: assert property (@(posedge clock) disable iff (!resetn) // [RULE_08]
        (cic_byp && $past(cic_byp)) |-> (r.integ == '0 && r.comb == '0))
        else $error("bypassed interpolator state not cleared");

    a_icic_frozen: assert property (@(posedge clock) disable iff (!resetn) // [RULE_09]
        (icic_byp && $past(icic_byp)) |-> $stable(r.icic))
        else $error("inverse cic moved while bypassed");

    a_nco_step: assert property (@(posedge clock) disable iff (!resetn) // [RULE_15]
        ##1 (r.phase == $past(r.phase) + $past(tw_act)))
        else $error("phase step differs from tuning word");

    a_isinc_frozen: assert property (@(posedge clock) disable iff (!resetn) // [RULE_20]
        (!isinc_en && $past(!isinc_en)) |-> $stable(r.isinc))
        else $error("inverse sinc taps moved while bypassed");

    a_dac_bypass: assert property (@(posedge clock) disable iff (!resetn) // [RULE_21]
        !isinc_en |=> (r.dac == qud_sat(22'($signed($past(r.mod))))))
        else $error("bypassed output not one clock behind modulator");

    a_mod_sign: assert property (@(posedge clock) disable iff (!resetn) // [RULE_14]
        1'b1 |=> (r.mod == 17'(($past(inv) ? $past(prod_i) + $past(prod_q)
                                : $past(prod_i) - $past(prod_q)) >>> qud_pkg::QUD_MOD_SHIFT)))
        else $error("modulator sum sign wrong for invert bit");
endmodule : qud_datapath
`default_nettype wire

// [logic/qud_fifo.sv]
// Purpose: Sample FIFO between the word source and the pair assembler
// Assumes: DEPTH is a power of two
// Notes:   Ready comes from a flop so the source sees a clean level
`timescale 1ns/100ps
`default_nettype none
module qud_fifo #(
    parameter int W     = 14,
    parameter int DEPTH = 8
) (
    input  wire logic         clock,
    input  wire logic         resetn,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
        logic                    rdy;
    } qud_fifo_state_type;

    qud_fifo_state_type r;
    qud_fifo_state_type n;

    always_comb begin
        n = r;
        if (in_valid && r.rdy) begin
            n.mem[r.wp] = in_data;
            n.wp        = r.wp + 1'b1;
        end
        if (out_ready && out_valid) begin
            n.rp = r.rp + 1'b1;
        end
        n.cnt = r.cnt + (AW+1)'(in_valid && r.rdy) - (AW+1)'(out_ready && out_valid);
        // Stalled drain lets it fill and drop ready
        n.rdy = (n.cnt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign in_ready  = r.rdy;
    assign out_valid = (r.cnt != '0);
    assign out_data  = r.mem[r.rp];
endmodule : qud_fifo
`default_nettype wire

// [logic/qud_pkg.sv]
// Purpose: Shared constants of the quadrature upconvert datapath
// Assumes: Byte-wide control port, one core sample clock
// Notes:   Offsets are positions within an eight-address profile block, not control addresses
package qud_pkg;
    localparam int QUD_IN_W       = 14;
    localparam int QUD_W          = 16;
    localparam int QUD_CIC_W      = 40;
    localparam int QUD_CIC_ORDER  = 5;
    localparam int QUD_NPROF      = 4;
    localparam int QUD_FIFO_DEPTH = 8;
    localparam int QUD_HB_SHIFT   = 4;
    localparam int QUD_MOD_SHIFT  = 11;
    localparam int QUD_ICIC_SHIFT = 3;
    localparam int QUD_ISINC_SHIFT = 4;
    localparam int QUD_CIC_LOG_MUL = 4;

    // Control address, profile block number and in-block offset
    localparam logic [5:0] QUD_ADDR_CTL   = 6'h06;
    localparam logic [2:0] QUD_PROF_BLK0  = 3'h1;
    localparam logic [2:0] QUD_OFS_CFG    = 3'h4;

    // Field positions
    localparam int QUD_CTL_ICIC_BYP = 0;
    localparam int QUD_CTL_ISINC_EN = 1;
    localparam int QUD_CFG_INV      = 7;
    localparam int QUD_CFG_BYP      = 6;

    // Reset and limits
    localparam logic [7:0]  QUD_REG_RST   = 8'h00;
    localparam logic [5:0]  QUD_RATE_MIN  = 6'h02;
    localparam logic [5:0]  QUD_RATE_BYP  = 6'h01;
    localparam logic [1:0]  QUD_Q_LAST    = 2'h3;
    localparam logic [5:0]  QUD_QUARTER   = 6'h10;

    // Filter coefficients and DAC clamp limits
    localparam logic signed [19:0] QUD_HB_C    = 20'sh00009;
    localparam logic signed [17:0] QUD_ICIC_C  = 18'sh00002;
    localparam logic signed [21:0] QUD_ISINC_C = 22'sh0000C;
    localparam logic signed [21:0] QUD_DAC_MAX = 22'sh001FFF;
    localparam logic signed [21:0] QUD_DAC_MIN = -22'sh002000;

    // Quarter-wave sine, mid-bin samples, 11-bit magnitude
    localparam logic [15:0][10:0] QUD_SINE_LUT = {
        11'h7FD, 11'h7E9, 11'h7C2, 11'h787, 11'h73A, 11'h6DC, 11'h66C, 11'h5ED,
        11'h55F, 11'h4C3, 11'h41C, 11'h36B, 11'h2B2, 11'h1F1, 11'h12C, 11'h064};
endpackage : qud_pkg

// [tb/qud_datapath_tb.sv]
// Purpose: Self-checking bench for the quadrature upconvert datapath
// Assumes: Carrier phase stays at zero until a tuning word is loaded
// Notes:   DC inputs keep the expected output signs simple
`timescale 1ns/100ps
`default_nettype none
module qud_datapath_tb;
    localparam logic [31:0] TW = 32'h556AAAAB;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        tx_enable = 1'b0;
    logic        src_en = 1'b0;
    logic [1:0]  profile_sel = 2'h0;
    logic [5:0]  reg_addr = 6'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic [13:0] i_word = 14'h0000;
    logic [13:0] q_word = 14'h0000;
    logic [13:0] in_data;
    logic        in_valid;
    logic        in_ready;
    logic [7:0]  reg_rdata;
    logic [13:0] dac_data;
    logic        pair_underrun;
    logic [7:0]  rd;
    logic signed [13:0] a;
    logic signed [13:0] b;
    int          taken, n0, k, err_total = 0, checks_done = 0, cycles = 0;

    always #10 clock = ~clock;

    qud_datapath uut (.clock(clock), .resetn(resetn), .in_data(in_data),
        .in_valid(in_valid), .in_ready(in_ready), .tx_enable(tx_enable),
        .profile_sel(profile_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_rdata(reg_rdata), .dac_data(dac_data),
        .pair_underrun(pair_underrun));
    qud_source src (.clock(clock), .enable(src_en), .in_ready(in_ready),
        .i_word(i_word), .q_word(q_word), .in_data(in_data),
        .in_valid(in_valid), .taken(taken));

    task automatic end_sim;
        $display("Checks %0d, errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic fail(input string msg);
        err_total++;
        $display("Error at %0t: %s", $time, msg);
    endtask : fail
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks_done++;
        if (got !== exp) fail(msg);
    endtask : chk8
    task automatic chk_ok(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) fail(msg);
    endtask : chk_ok
    task automatic reg_wr(input logic [5:0] ad, input logic [7:0] d);
        @(posedge clock);
        #1;
        reg_addr = ad;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge clock);
        #1;
        reg_write = 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [5:0] ad, output logic [7:0] d);
        @(posedge clock);
        #1;
        reg_addr = ad;
        @(posedge clock);
        #1;
        d = reg_rdata;
    endtask : reg_rd
    task automatic count_under(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clock);
            #1;
            if (pair_underrun === 1'b1) c++;
        end
    endtask : count_under
    // Long settle: the filter chain has tens of clocks of latency
    task automatic settle_dac(input logic [7:0] cfg, output logic signed [13:0] v);
        reg_wr(6'h0C, cfg);
        repeat (800) @(posedge clock);
        #1;
        v = dac_data;
    endtask : settle_dac
    // Source never stalls, so the FIFO stays full and words track pair slots
    task automatic rate_win(input logic [7:0] cfg, input int exp);
        reg_wr(6'h0C, cfg);
        repeat (300) @(posedge clock);
        n0 = taken;
        repeat (1008) @(posedge clock);
        chk_ok((taken - n0 >= exp - 3) && (taken - n0 <= exp + 3), "word rate");
    endtask : rate_win

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail("timeout");
            end_sim();
        end
    end

    initial begin
        repeat (6) @(posedge clock);
        chk_ok(in_ready === 1'b0 && dac_data === 14'h0000, "reset outputs");
        #1;
        resetn = 1'b1;
        for (k = 0; k < 5; k++) begin
            reg_rd(6'h08 + 6'(k), rd);
            chk8(rd, 8'h00, "reset value");
        end
        reg_rd(qud_pkg::QUD_ADDR_CTL, rd);
        chk8(rd, 8'h00, "control reset value");
        reg_rd(6'h3F, rd);
        chk8(rd, 8'h00, "unmapped read");
        $display("Test registers done");
        tx_enable = 1'b1;
        count_under(20, n0);
        chk_ok(n0 >= 2, "no underrun pulse");
        src_en = 1'b1;
        repeat (100) @(posedge clock);
        count_under(200, n0);
        chk_ok(n0 == 0, "underrun while fed");
        $display("Test underrun done");
        i_word = 14'h1000;
        settle_dac(8'h02, a);
        chk_ok(a > 0, "cosine path sign");
        i_word = 14'h0000;
        q_word = 14'h1000;
        settle_dac(8'h02, a);
        settle_dac(8'h82, b);
        chk_ok(a < 0 && b > 0, "invert sign");
        i_word = 14'h1000;
        q_word = 14'h0000;
        settle_dac(8'h02, a);
        reg_wr(6'h06, 8'h02);
        settle_dac(8'h02, b);
        chk_ok(b > 0 && b < a, "inverse sinc gain");
        reg_wr(6'h06, 8'h01);
        reg_rd(6'h06, rd);
        chk8(rd, 8'h01, "control readback");
        reg_wr(6'h06, 8'h00);
        $display("Test modulator done");
        rate_win(8'h02, 252);
        rate_win(8'h3F, 8);
        rate_win(8'h45, 504);
        rate_win(8'h05, 101);
        $display("Test rates done");
        for (k = 0; k < 4; k++) reg_wr(6'h08 + 6'(k), TW[8*k +: 8]);
        for (k = 0; k < 4; k++) begin
            reg_rd(6'h08 + 6'(k), rd);
            chk8(rd, TW[8*k +: 8], "tuning byte");
        end
        settle_dac(8'h02, a);
        @(posedge clock);
        #1;
        b = dac_data;
        @(posedge clock);
        #1;
        // Two mirrored bins can match once, never twice in a row
        chk_ok(a != b || b != $signed(dac_data), "carrier not moving");
        profile_sel = 2'h1;
        repeat (800) @(posedge clock);
        #1;
        a = dac_data;
        @(posedge clock);
        #1;
        chk_ok(a === dac_data, "profile word not used");
        $display("Test carrier done");
        tx_enable = 1'b0;
        src_en = 1'b0;
        repeat (600) @(posedge clock);
        #1;
        chk_ok(dac_data === 14'h0000, "flush not zero");
        $display("Test flush done");
        end_sim();
    end
endmodule : qud_datapath_tb
`default_nettype wire

// [tb/qud_source.sv]
// Purpose: Upstream sample source for the datapath bench
// Assumes: Words go I then Q from the first one after enable
// Notes:   Idle data toggles so a stale word is never read as valid
`timescale 1ns/100ps
`default_nettype none
module qud_source (
    input  wire logic        clock,
    input  wire logic        enable,
    input  wire logic        in_ready,
    input  wire logic [13:0] i_word,
    input  wire logic [13:0] q_word,
    output logic [13:0]      in_data,
    output logic             in_valid,
    output int               taken
);
    logic rdy_s;
    logic en_s;
    logic q_next;
    initial begin
        in_data = 14'h0000;
        in_valid = 1'b0;
        q_next = 1'b0;
        taken = 0;
    end
    // Ready is a flop, so its level at the falling edge is the one sampled
    always @(negedge clock) begin
        rdy_s = in_ready;
    end
    always @(posedge clock) begin
        en_s = enable;
        if (in_valid && rdy_s) begin
            taken++;
            q_next = !q_next;
        end
        #1;
        in_valid = en_s;
        if (!en_s) begin
            q_next = 1'b0;
            in_data = ~in_data;
        end else begin
            in_data = q_next ? q_word : i_word;
        end
    end
endmodule : qud_source
`default_nettype wire
